// ===== core/sas_defines.vh
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define SAS_OP_POWER_DOWN   16'h0003
`define SAS_OP_LIT_SUB_HI   8'h08
`define SAS_OP_REV_SUB_HI   6'h15
`define SAS_OP_FILE_SUB_HI  6'h17

// ----------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------
`define SAS_OFS_WREG        5'h00
`define SAS_OFS_STATUS      5'h04
`define SAS_OFS_BANK        5'h08
`define SAS_OFS_CTRL        5'h0C
`define SAS_OFS_WDOG        5'h10
`define SAS_OFS_POSTSC      5'h14
`define SAS_OFS_SLEEP       5'h18

// ----------------------------------------------------------------
// status field positions and reset values
// ----------------------------------------------------------------
`define SAS_ST_C            0
`define SAS_ST_DC           1
`define SAS_ST_Z            2
`define SAS_ST_OV           3
`define SAS_ST_N            4
`define SAS_ST_PD           5
`define SAS_ST_TO           6
`define SAS_STATUS_RST      7'h60
`define SAS_CTRL_EXT        0

// ----------------------------------------------------------------
// addressing constants
// ----------------------------------------------------------------
`define SAS_IDX_LIMIT       8'h5F
`define SAS_ACCESS_SPLIT    8'h60
`define SAS_ACCESS_HI_BANK  4'hF
`define SAS_ACCESS_LO_BANK  4'h0

`endif

// ===== core/sas_sub_alu.v
`default_nettype none

// ----------------------------------------------------------------
// eight bit subtractor: minuend - subtrahend - (not carry_in)
// ----------------------------------------------------------------
module sas_sub_alu (
    input  wire [7:0] minuend_in,
    input  wire [7:0] subtrahend_in,
    input  wire       carry_in,
    output wire [7:0] result_out,
    output wire       carry_out,
    output wire       digit_carry_out,
    output wire       zero_out,
    output wire       overflow_out,
    output wire       negative_out
);
    // two's complement: add the inverted subtrahend plus carry
    wire [8:0] full_sum;   // carry out lands in bit 8
    wire [4:0] low_sum;    // nibble carry lands in bit 4

    assign full_sum        = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {8'h00, carry_in};
    assign low_sum         = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]} + {4'h0, carry_in};
    assign result_out      = full_sum[7:0];
    // carry set means no borrow happened
    assign carry_out       = full_sum[8];
    assign digit_carry_out = low_sum[4];
    assign zero_out        = (full_sum[7:0] == 8'h00);
    // signed overflow: operands differ in sign and result sign left the minuend's
    assign overflow_out    = (minuend_in[7] ^ subtrahend_in[7]) & (full_sum[7] ^ minuend_in[7]);
    assign negative_out    = full_sum[7];
endmodule

`default_nettype wire

// ===== core/sas_exec.v
// Summary of operation
// - power-down decode clears pd, sets to
// - power-down zeroes watchdog count and postscaler
// - sleep entered in fourth phase, oscillator stopped
// - watchdog wake from sleep clears to flag
// - reverse borrow subtract: w - f - not carry
// - d low writes w, high writes file
// - a low access bank, high uses bank select
// - a low, ext set, f<=5Fh: indexed offset
// - subtracts update n, ov, c, dc, z
// - file subtract computes f minus w
// - carry is inverted borrow for subtraction
`include "sas_defines.vh"
`default_nettype none

module sas_exec (
    input  wire        sys_clk_in,
    input  wire        reset_n_in,
    // program memory side
    input  wire [15:0] instr_in,
    input  wire        instr_valid_in,
    output wire        instr_ready_out,
    // data memory side
    output reg  [11:0] file_addr_out,
    output reg         file_rd_en_out,
    input  wire [7:0]  file_rd_data_in,
    output reg         file_wr_en_out,
    output reg  [7:0]  file_wr_data_out,
    input  wire [11:0] idx_base_in,
    // watchdog and oscillator
    input  wire        wdt_tick_in,
    input  wire        wdt_wake_in,
    output reg         osc_run_out,
    output reg         sleeping_out,
    // avalon-mm slave
    input  wire [4:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out
);
    // ----------------------------------------------------------------
    // states and decode classes
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_Q1    = 3'h1;
    localparam [2:0] ST_Q2    = 3'h2;
    localparam [2:0] ST_Q3    = 3'h3;
    localparam [2:0] ST_Q4    = 3'h4;
    localparam [2:0] ST_SLEEP = 3'h5;

    localparam [2:0] OP_NONE  = 3'h0;
    localparam [2:0] OP_PDOWN = 3'h1;
    localparam [2:0] OP_LSUB  = 3'h2;
    localparam [2:0] OP_RSUB  = 3'h3;
    localparam [2:0] OP_FSUB  = 3'h4;

    // ----------------------------------------------------------------
    // operand address selection, shared by decode paths
    // ----------------------------------------------------------------
    function [11:0] operand_addr;
        input       acc_bit;
        input [7:0] faddr;
        input [3:0] bank;
        input       ext_en;
        input [11:0] idx_base;
        begin
            if (!acc_bit && ext_en && (faddr <= `SAS_IDX_LIMIT)) begin
                // indexed literal offset from the index base
                operand_addr = idx_base + {4'h0, faddr};
            end else if (!acc_bit) begin
                // access bank: low part is ram, upper part is sfr space
                operand_addr = (faddr < `SAS_ACCESS_SPLIT) ? {`SAS_ACCESS_LO_BANK, faddr}
                                                           : {`SAS_ACCESS_HI_BANK, faddr};
            end else begin
                operand_addr = {bank, faddr};   // bank select picks the bank
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [2:0]  state_r;          // phase sequencer
    reg  [15:0] instr_r;          // captured instruction word
    reg  [2:0]  op_r;             // decoded class
    reg  [7:0]  wreg_r;           // working register
    reg  [6:0]  status_r;         // n ov z dc c plus pd and to
    reg  [3:0]  bank_select_reg;  // bank select register
    reg         ext_en_r;         // extended instruction set enable
    reg  [7:0]  watchdog_counter; // watchdog count
    reg  [3:0]  postscaler_r;     // watchdog postscaler
    reg  [7:0]  operand_r;        // operand read in the second phase
    reg  [7:0]  result_r;         // result held for the write phase
    reg  [4:0]  flags_r;          // flags held for the write phase
    reg         ack_r;            // bus answer pending

    // decoded fields of the held word
    wire        dest_bit = instr_r[9];
    wire        acc_bit  = instr_r[8];
    wire [7:0]  faddr    = instr_r[7:0];

    // alu hookup
    reg  [7:0]  alu_min;
    reg  [7:0]  alu_sub;
    reg         alu_cin;
    wire [7:0]  alu_res;
    wire        alu_c;
    wire        alu_dc;
    wire        alu_z;
    wire        alu_ov;
    wire        alu_n;

    // bus strobes
    wire        bus_req   = avs_read_in | avs_write_in;
    wire        bus_wr_go = avs_write_in & ack_r & avs_byteenable_in[0];
    wire        core_w_wr = (state_r == ST_Q4) && (op_r == OP_LSUB || ((op_r == OP_RSUB || op_r == OP_FSUB)
                            && !dest_bit));
    wire        core_flag = (state_r == ST_Q4) && (op_r == OP_LSUB || op_r == OP_RSUB || op_r == OP_FSUB);

    // the bus waits one cycle so read data can come from a flop
    assign avs_waitrequest_out = bus_req & ~ack_r;
    // a power-down ending in sleep takes no new word until wake
    assign instr_ready_out     = (state_r == ST_IDLE) || (state_r == ST_Q4 && op_r != OP_PDOWN);

    // ----------------------------------------------------------------
    // operand selection per subtract flavour
    // ----------------------------------------------------------------
    always @* begin
        alu_min = operand_r;
        alu_sub = wreg_r;
        alu_cin = 1'b1;
        case (op_r)
            OP_LSUB: begin
                alu_min = instr_r[7:0];          // literal minus w
                alu_sub = wreg_r;
                alu_cin = 1'b1;
            end
            OP_RSUB: begin
                alu_min = wreg_r;                // w minus f minus borrow
                alu_sub = operand_r;
                alu_cin = status_r[`SAS_ST_C];   // clear carry takes one more
            end
            OP_FSUB: begin
                alu_min = operand_r;             // f minus w
                alu_sub = wreg_r;
                alu_cin = 1'b1;
            end
            default: begin
                alu_cin = 1'b1;
            end
        endcase
    end

    sas_sub_alu u_alu (
        .minuend_in      (alu_min),
        .subtrahend_in   (alu_sub),
        .carry_in        (alu_cin),
        .result_out      (alu_res),
        .carry_out       (alu_c),
        .digit_carry_out (alu_dc),
        .zero_out        (alu_z),
        .overflow_out    (alu_ov),
        .negative_out    (alu_n)
    );

    // ----------------------------------------------------------------
    // phase sequencer, one instruction per four phases
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r      <= ST_IDLE;
            instr_r      <= 16'h0000;
            op_r         <= OP_NONE;
            operand_r    <= 8'h00;
            result_r     <= 8'h00;
            flags_r      <= 5'h00;
            osc_run_out  <= 1'b1;
            sleeping_out <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE, ST_Q4: begin
                    if (state_r == ST_Q4 && op_r == OP_PDOWN) begin
                        // oscillator halts in the last phase
                        state_r      <= ST_SLEEP;
                        osc_run_out  <= 1'b0;
                        sleeping_out <= 1'b1;
                    end else if (instr_valid_in) begin
                        // word taken, decode follows
                        instr_r <= instr_in;
                        state_r <= ST_Q1;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_Q1: begin
                    // decode the held word
                    if (instr_r == `SAS_OP_POWER_DOWN)
                        op_r <= OP_PDOWN;
                    else if (instr_r[15:8] == `SAS_OP_LIT_SUB_HI)
                        op_r <= OP_LSUB;
                    else if (instr_r[15:10] == `SAS_OP_REV_SUB_HI)
                        op_r <= OP_RSUB;
                    else if (instr_r[15:10] == `SAS_OP_FILE_SUB_HI)
                        op_r <= OP_FSUB;
                    else
                        op_r <= OP_NONE;   // foreign opcodes pass as no-ops
                    state_r <= ST_Q2;
                end
                ST_Q2: begin
                    // read register f; power-down clears pd and sets to here
                    operand_r <= file_rd_data_in;
                    state_r   <= ST_Q3;
                end
                ST_Q3: begin
                    // process data, result held for the write
                    result_r <= alu_res;
                    flags_r  <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
                    state_r  <= ST_Q4;
                end
                ST_SLEEP: begin
                    if (wdt_wake_in) begin
                        // only the watchdog wakes this block
                        state_r      <= ST_IDLE;
                        op_r         <= OP_NONE;
                        osc_run_out  <= 1'b1;
                        sleeping_out <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // data memory strobes, registered
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            file_addr_out    <= 12'h000;
            file_rd_en_out   <= 1'b0;
            file_wr_en_out   <= 1'b0;
            file_wr_data_out <= 8'h00;
        end else begin
            file_rd_en_out <= 1'b0;
            file_wr_en_out <= 1'b0;
            if (state_r == ST_Q1) begin
                // address is out before the read phase samples
                file_addr_out  <= operand_addr(instr_r[8], instr_r[7:0], bank_select_reg, ext_en_r, idx_base_in);
                file_rd_en_out <= (instr_r[15:10] == `SAS_OP_REV_SUB_HI) ||
                                  (instr_r[15:10] == `SAS_OP_FILE_SUB_HI);
            end
            if (state_r == ST_Q3 && (op_r == OP_RSUB || op_r == OP_FSUB) && dest_bit) begin
                // result goes back to f, strobe lands in the fourth phase
                file_wr_en_out   <= 1'b1;
                file_wr_data_out <= alu_res;
            end
        end
    end

    // ----------------------------------------------------------------
    // w, status, bank and control; core updates win over the bus
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wreg_r          <= 8'h00;
            status_r        <= `SAS_STATUS_RST;
            bank_select_reg <= 4'h0;
            ext_en_r        <= 1'b0;
        end else begin
            // software writes first, hardware below overrides them
            if (bus_wr_go && avs_address_in == `SAS_OFS_WREG)
                wreg_r <= avs_writedata_in[7:0];
            if (bus_wr_go && avs_address_in == `SAS_OFS_STATUS)
                status_r <= avs_writedata_in[6:0];
            if (bus_wr_go && avs_address_in == `SAS_OFS_BANK)
                bank_select_reg <= avs_writedata_in[3:0];
            if (bus_wr_go && avs_address_in == `SAS_OFS_CTRL)
                ext_en_r <= avs_writedata_in[`SAS_CTRL_EXT];
            if (core_w_wr)
                wreg_r <= result_r;                 // d low or literal form
            if (core_flag)
                status_r[4:0] <= flags_r;
            if (state_r == ST_Q2 && op_r == OP_PDOWN) begin
                status_r[`SAS_ST_PD] <= 1'b0;
                status_r[`SAS_ST_TO] <= 1'b1;
            end
            if (state_r == ST_SLEEP && wdt_wake_in)
                status_r[`SAS_ST_TO] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // watchdog count and postscaler
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            watchdog_counter <= 8'h00;
            postscaler_r     <= 4'h0;
        end else if (state_r == ST_Q3 && op_r == OP_PDOWN) begin
            // the clear beats a tick landing in the same cycle
            watchdog_counter <= 8'h00;
            postscaler_r     <= 4'h0;
        end else if (wdt_tick_in) begin
            postscaler_r <= postscaler_r + 4'h1;
            if (postscaler_r == 4'hF)
                watchdog_counter <= watchdog_counter + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // avalon answer and read data
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_r            <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end else begin
            // answer on the second cycle of every request
            ack_r <= bus_req & ~ack_r;
            if (avs_read_in && !ack_r) begin
                case (avs_address_in)
                    `SAS_OFS_WREG:   avs_readdata_out <= {24'h000000, wreg_r};
                    `SAS_OFS_STATUS: avs_readdata_out <= {25'h0000000, status_r};
                    `SAS_OFS_BANK:   avs_readdata_out <= {28'h0000000, bank_select_reg};
                    `SAS_OFS_CTRL:   avs_readdata_out <= {31'h00000000, ext_en_r};
                    `SAS_OFS_WDOG:   avs_readdata_out <= {24'h000000, watchdog_counter};
                    `SAS_OFS_POSTSC: avs_readdata_out <= {28'h0000000, postscaler_r};
                    `SAS_OFS_SLEEP:  avs_readdata_out <= {30'h00000000, osc_run_out, sleeping_out};
                    default:         avs_readdata_out <= 32'h00000000;   // unmapped reads zero
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/sas_exec_assertions.sv
`default_nettype none
// ----------------------------------------------------------------
// port checker of the execute block
// ----------------------------------------------------------------
module sas_exec_checker (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [15:0] instr_in,
    input  wire logic        instr_valid_in,
    input  wire logic        instr_ready_out,
    input  wire logic [11:0] file_addr_out,
    input  wire logic        file_rd_en_out,
    input  wire logic        file_wr_en_out,
    input  wire logic        wdt_wake_in,
    input  wire logic        osc_run_out,
    input  wire logic        sleeping_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic take = instr_valid_in && instr_ready_out; // word taken
    wire logic fsub = instr_in[15:12] == 4'h5 && instr_in[10]; // reverse and file subtracts
    a_sleep_entry: assert property (take && instr_in == 16'h0003 |-> ##[4:5] (sleeping_out && !osc_run_out))
        else $error("no sleep after power-down");
    a_osc_pair: assert property (sleeping_out != osc_run_out)
        else $error("osc and sleep disagree");
    a_sleep_refuse: assert property (sleeping_out |-> !instr_ready_out)
        else $error("word taken in sleep");
    a_wake_exit: assert property (sleeping_out && wdt_wake_in |=> !sleeping_out && osc_run_out)
        else $error("watchdog wake ignored");
    a_read_phase: assert property (take && fsub |-> ##2 file_rd_en_out)
        else $error("no operand read");
    a_file_dest: assert property (take && fsub && instr_in[9] |-> ##4 file_wr_en_out)
        else $error("file not written");
    a_w_dest: assert property (take && fsub && !instr_in[9] |-> ##1 !file_wr_en_out [*4])
        else $error("file written for w");
    a_lit_nofile: assert property (take && instr_in[15:8] == 8'h08 |-> ##1 (!file_rd_en_out && !file_wr_en_out) [*4])
        else $error("literal touched memory");
    a_ready_gap: assert property (take |=> !instr_ready_out [*3])
        else $error("word taken too early");
    a_bank_low: assert property (take && fsub && instr_in[8] |-> ##2 file_addr_out[7:0] == $past(instr_in[7:0], 2))
        else $error("bank address wrong");
    a_access_hi: assert property (take && fsub && !instr_in[8] && instr_in[7:0] >= 8'h60
        |-> ##2 file_addr_out == {4'hF, $past(instr_in[7:0], 2)})
        else $error("access address wrong");
endmodule
`default_nettype wire

// ===== tb/sas_prog_mem_model.sv
`default_nettype none
// ----------------------------------------------------------------
// program and data memory of the execute block
// ----------------------------------------------------------------
module sas_prog_mem_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ready_in,
    output var  logic [15:0] instr_out,
    output var  logic        valid_out,
    input  wire logic [11:0] addr_in,
    input  wire logic        rd_en_in,
    input  wire logic        wr_en_in,
    input  wire logic [7:0]  wr_data_in,
    output wire logic [7:0]  rd_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] q [$];          // words to fetch
    logic [7:0]  mem [0:4095];   // data memory
    logic [7:0]  last_rd = 8'h5A; // last byte handed out
    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask
    // offer a word until taken; idle shows inverted junk
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            instr_out <= 16'hFFFF;
        end else if (!valid_out || ready_in) begin
            if (q.size() > 0) begin
                instr_out <= q.pop_front();
                valid_out <= 1'b1;
            end else begin
                valid_out <= 1'b0;
                instr_out <= ~instr_out;
            end
        end
    end
    // writes land at the end of the strobe
    always @(posedge clk_in) begin
        if (rd_en_in) last_rd <= mem[addr_in];
        if (wr_en_in) mem[addr_in] <= wr_data_in;
    end
    // deselected read shows the inverted last byte
    assign rd_data_out = rd_en_in ? mem[addr_in] : ~last_rd;
endmodule
`default_nettype wire

// ===== tb/sleep_and_subtract_exec_tb.sv
`default_nettype none
// ----------------------------------------------------------------
// bench of the execute block
// ----------------------------------------------------------------
module sleep_and_subtract_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [15:0] w; logic [11:0] a; logic [7:0] fv, wv, res; logic ci, ext, tof; logic [4:0] fl;} sas_case_t;
    logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, wake = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdat = 32'h0, rdata, rv;
    logic [11:0] idx_base = 12'h200, f_addr;
    logic [15:0] instr;
    logic valid, ready, wait_r, f_rd, f_wr, osc, slp;
    logic [7:0] f_rdat, f_wdat;
    int fail_count = 0, checks = 0;
    // ----------------------------------------------------------------
    // design and partner
    // ----------------------------------------------------------------
    sas_exec dut (.sys_clk_in(clk), .reset_n_in(rst_n), .instr_in(instr), .instr_valid_in(valid),
        .instr_ready_out(ready), .file_addr_out(f_addr), .file_rd_en_out(f_rd), .file_rd_data_in(f_rdat),
        .file_wr_en_out(f_wr), .file_wr_data_out(f_wdat), .idx_base_in(idx_base), .wdt_tick_in(tick),
        .wdt_wake_in(wake), .osc_run_out(osc), .sleeping_out(slp), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_r));
    sas_prog_mem_model pm (.clk_in(clk), .rst_n_in(rst_n), .ready_in(ready), .instr_out(instr), .valid_out(valid),
        .addr_in(f_addr), .rd_en_in(f_rd), .wr_en_in(f_wr), .wr_data_in(f_wdat), .rd_data_out(f_rdat));
    initial begin
        forever #25 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("fails %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        addr <= a;
        rd <= !w;
        wr <= w;
        wdat <= d;
        @(posedge clk);
        while (wait_r !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) fail_count++;
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rv);
    endtask
    // queue a word, wait until it retires
    task automatic exec(input logic [15:0] w);
        int n = 0;
        pm.push(w);
        repeat (2) @(negedge clk);
        while ((valid === 1'b1 || pm.q.size() > 0) && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) fail_count++;
        repeat (5) @(posedge clk);
    endtask
    task automatic pulse_tick();
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // word, addr, f, w, result, c in, ext, to file, flags
    // ----------------------------------------------------------------
    sas_case_t tc [10] = '{
        '{16'h5E70, 12'hF70, 8'h03, 8'h02, 8'h01, 1'b0, 1'b0, 1'b1, 5'h03},
        '{16'h5C71, 12'hF71, 8'h01, 8'h02, 8'hFF, 1'b0, 1'b0, 1'b0, 5'h10},
        '{16'h5672, 12'hF72, 8'h02, 8'h02, 8'hFF, 1'b0, 1'b0, 1'b1, 5'h10},
        '{16'h5473, 12'hF73, 8'h02, 8'h05, 8'h03, 1'b1, 1'b0, 1'b0, 5'h03},
        '{16'h0802, 12'h000, 8'h00, 8'h02, 8'h00, 1'b0, 1'b0, 1'b0, 5'h07},
        '{16'h0880, 12'h000, 8'h00, 8'h01, 8'h7F, 1'b0, 1'b0, 1'b0, 5'h09},
        '{16'h5F10, 12'h310, 8'h09, 8'h04, 8'h05, 1'b0, 1'b0, 1'b1, 5'h03},
        '{16'h5E05, 12'h205, 8'h08, 8'h01, 8'h07, 1'b0, 1'b1, 1'b1, 5'h03},
        '{16'h5E5F, 12'h25F, 8'h10, 8'h01, 8'h0F, 1'b1, 1'b1, 1'b1, 5'h01},
        '{16'h5E60, 12'hF60, 8'h20, 8'h01, 8'h1F, 1'b0, 1'b1, 1'b1, 5'h01}};
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, 5'h04, 32'h0, rv); check(rv, 32'h60);
        bus(1'b0, 5'h1C, 32'h0, rv); check(rv, 32'h0);
        bus(1'b0, 5'h18, 32'h0, rv); check(rv, 32'h2);
        bus_wr(5'h08, 32'h3);
        foreach (tc[i]) begin
            bus_wr(5'h0C, {31'h0, tc[i].ext});
            bus_wr(5'h00, {24'h0, tc[i].wv});
            bus_wr(5'h04, {31'h30, tc[i].ci});
            pm.mem[tc[i].a] = tc[i].fv;
            exec(tc[i].w);
            bus(1'b0, 5'h00, 32'h0, rv); check(rv, {24'h0, tc[i].tof ? tc[i].wv : tc[i].res});
            bus(1'b0, 5'h04, 32'h0, rv); check(rv, {25'h0, 2'b11, tc[i].fl});
            check(32'(pm.mem[tc[i].a]), {24'h0, tc[i].tof ? tc[i].res : tc[i].fv});
        end
        // back to back literal subtracts
        bus_wr(5'h00, 32'h1);
        pm.push(16'h0805);
        exec(16'h0803);
        bus(1'b0, 5'h00, 32'h0, rv); check(rv, 32'hFF);
        bus(1'b0, 5'h04, 32'h0, rv); check(rv, 32'h70);
        // power-down, then watchdog wake
        bus_wr(5'h04, 32'h20);
        repeat (17) pulse_tick();
        bus(1'b0, 5'h10, 32'h0, rv); check(rv, 32'h1);
        bus(1'b0, 5'h14, 32'h0, rv); check(rv, 32'h1);
        exec(16'h0003);
        bus(1'b0, 5'h04, 32'h0, rv); check(rv, 32'h40);
        bus(1'b0, 5'h10, 32'h0, rv); check(rv, 32'h0);
        bus(1'b0, 5'h14, 32'h0, rv); check(rv, 32'h0);
        bus(1'b0, 5'h18, 32'h0, rv); check(rv, 32'h1);
        check({31'h0, slp}, 32'h1);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b0, 5'h04, 32'h0, rv); check(rv, 32'h0);
        bus(1'b0, 5'h18, 32'h0, rv); check(rv, 32'h2);
        finish_test();
    end
    // watchdog: tests need under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule
bind sas_exec sas_exec_checker u_chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .file_addr_out(file_addr_out),
    .file_rd_en_out(file_rd_en_out), .file_wr_en_out(file_wr_en_out), .wdt_wake_in(wdt_wake_in),
    .osc_run_out(osc_run_out), .sleeping_out(sleeping_out));
`default_nettype wire
